//--- verilog/rfc_pkg.sv
`default_nettype none
package rfc_pkg;
  localparam int RFC_CLK_MHZ = 250;
  localparam int RFC_SMP_MHZ = 32;
  localparam int RFC_CAL_MS = 500;
  localparam int RFC_CAL_CYC = RFC_CAL_MS * RFC_CLK_MHZ * 1000;
  localparam int RFC_ADDR_W = 7;
  localparam int RFC_DATA_W = 8;
  localparam int RFC_SPI_BITS = 1 + RFC_ADDR_W + RFC_DATA_W;
  localparam int RFC_SPI_DIV = 8;
  localparam int RFC_SPI_HALVES = 2 * RFC_SPI_BITS;
  localparam int RFC_NUM_PATHS = 10;
  localparam int RFC_IF_W = 16;
  localparam int RFC_PH_OUT_W = 8;
  localparam int RFC_NIB_W = 4;
  localparam int RFC_GRP_LEN = 8;
  localparam int RFC_IQ_W = 12;
  localparam int RFC_CORR_FRAC = 10;
  localparam int RFC_PKT_W = 32;
  localparam int RFC_FIFO_DEPTH = 16;

  typedef struct packed {
    logic                  wr;
    logic [RFC_ADDR_W-1:0] addr;
    logic [RFC_DATA_W-1:0] data;
  } rfc_spi_req_t;

  typedef struct packed {
    logic signed [RFC_IQ_W-1:0] i;
    logic signed [RFC_IQ_W-1:0] q;
  } rfc_iq_t;

  typedef struct packed {
    logic radio;
    logic modem;
  } rfc_tx_cfg_t;

  typedef struct packed {
    logic i;
    logic q;
  } rfc_sd_t;

  typedef enum logic [1:0] {
    RFC_CTL_IDLE = 2'b00,
    RFC_CTL_CAL  = 2'b01,
    RFC_CTL_TX   = 2'b10
  } rfc_ctl_t;

  typedef enum logic [1:0] {
    RFC_SPI_IDLE  = 2'b00,
    RFC_SPI_SHIFT = 2'b01,
    RFC_SPI_END   = 2'b10
  } rfc_spi_st_t;
endpackage
`default_nettype wire

//--- verilog/rfc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_fifo
  import rfc_pkg::*;
#(
  parameter int WIDTH = RFC_PKT_W,
  parameter int DEPTH = RFC_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
  } rfc_fifo_st_t;

  rfc_fifo_st_t     s_r;
  rfc_fifo_st_t     s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
      s_nxt.wptr = s_r.wptr + 1'b1;
    if (pop)
      s_nxt.rptr = s_r.rptr + 1'b1;
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;

  always_ff @(posedge clock)
    if (push)
      mem[s_r.wptr] <= in_data;
endmodule
`default_nettype wire

//--- verilog/rfc_spi.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_spi
  import rfc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  cs_active_high,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire rfc_spi_req_t          req,
  output logic                       rd_valid,
  output logic [RFC_DATA_W-1:0]      rd_data,
  output logic                       sck,
  output logic                       mosi,
  output logic                       cs,
  input  wire logic                  miso
);
  typedef struct packed {
    rfc_spi_st_t             st;
    logic [2:0]              div;
    logic [5:0]              half;
    logic [RFC_SPI_BITS-1:0] shreg;
    logic [RFC_DATA_W-1:0]   rdsh;
    logic                    sck;
    logic                    act;
    logic                    cs_pin;
    logic                    rd_valid;
    logic [RFC_DATA_W-1:0]   rd_data;
    logic                    miso_m;
    logic                    miso_s;
  } rfc_spi_state_t;

  rfc_spi_state_t s_r;
  rfc_spi_state_t s_nxt;
  logic           tick;

  assign tick      = (s_r.div == 3'(RFC_SPI_DIV - 1));
  assign req_ready = (s_r.st == RFC_SPI_IDLE);
  assign rd_valid  = s_r.rd_valid;
  assign rd_data   = s_r.rd_data;
  assign sck       = s_r.sck;
  assign mosi      = s_r.shreg[RFC_SPI_BITS-1];
  assign cs        = s_r.cs_pin;

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.miso_m   = miso;
    s_nxt.miso_s   = s_r.miso_m;
    s_nxt.rd_valid = 1'b0;
    s_nxt.div      = tick ? '0 : s_r.div + 1'b1;
    unique case (s_r.st)
      RFC_SPI_IDLE:
      begin
        s_nxt.div = '0;
        if (req_valid)
        begin
          s_nxt.st    = RFC_SPI_SHIFT;
          s_nxt.shreg = {req.wr, req.addr, req.data}; // [R01]
          s_nxt.act   = 1'b1;
          s_nxt.half  = '0;
          s_nxt.sck   = 1'b0;
        end
      end
      RFC_SPI_SHIFT:
        if (tick)
        begin
          s_nxt.sck  = ~s_r.sck;
          s_nxt.half = s_r.half + 1'b1;
          if (!s_r.sck)
            s_nxt.rdsh = {s_r.rdsh[RFC_DATA_W-2:0], s_r.miso_s};
          else
            s_nxt.shreg = {s_r.shreg[RFC_SPI_BITS-2:0], 1'b0};
          if (s_r.half == 6'(RFC_SPI_HALVES - 1))
            s_nxt.st = RFC_SPI_END;
        end
      RFC_SPI_END:
        if (tick)
        begin
          s_nxt.act      = 1'b0;
          s_nxt.st       = RFC_SPI_IDLE;
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data  = s_r.rdsh;
        end
      default:
        s_nxt.st = RFC_SPI_IDLE;
    endcase
    s_nxt.cs_pin = cs_active_high ? s_nxt.act : ~s_nxt.act; // [R02]
  end

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
endmodule
`default_nettype wire

//--- verilog/rfc_top.sv
// Operation
// R01 - Radio serial word: write/read bit, 7-bit address, then 8 data bits.
// R02 - Software picks the active level of the radio serial chip select.
// R03 - During the 500 ms calibration no receive or transmit may start or continue.
// R04 - Calibration is run by the internal controller alone, host not involved.
// R05 - Calibration corrections are applied digitally inside our receive and transmit chains.
// R06 - Only one packet is transmitted at a time; no overlapping transmit.
// R07 - Starting a transmission aborts every receive in progress on all paths.
// R08 - Either modulation type can go out on either of the two radios.
// R09 - Receive and transmit sample interfaces are separate and independent.
// R10 - Transmit samples leave as a 1-bit sigma-delta stream at 32 MSps.
// R11 - Packets from all demodulation paths share one receive buffer until read.
// R12 - The single buffered packet goes through one chosen radio via one modem.
// R13 - Every demodulation path has its own intermediate-frequency offset.
// R14 - Receive front-end changes strobe and data on its rising clock edge.
// R15 - Sample-valid pulses every 8 clocks, framing eight 4-bit samples.
// R16 - A transmit request during calibration or transmission is rejected and flagged.
`timescale 1ns/1ps
`default_nettype none
module rfc_top
  import rfc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = RFC_CAL_CYC
) (
  input  wire logic                                      clock,
  input  wire logic                                      resetn,
  input  wire logic                                      cal_start,
  output logic                                           cal_busy,
  input  wire rfc_iq_t                                   cal_dc,
  input  wire logic signed [RFC_IQ_W-1:0]                cal_gain,
  input  wire logic signed [RFC_IQ_W-1:0]                cal_phase,
  input  wire logic                                      cs_active_high,
  input  wire logic                                      spi_req_valid,
  output logic                                           spi_req_ready,
  input  wire rfc_spi_req_t                              spi_req,
  output logic                                           spi_rd_valid,
  output logic [RFC_DATA_W-1:0]                          spi_rd_data,
  output logic                                           spi_sck,
  output logic                                           spi_mosi,
  output logic                                           spi_cs,
  input  wire logic                                      spi_miso,
  input  wire logic                                      rx_clk_pin,
  input  wire logic                                      rx_valid_pin,
  input  wire logic [RFC_NIB_W-1:0]                      rx_data_pin,
  input  wire logic [RFC_NUM_PATHS-1:0][RFC_IF_W-1:0]    if_offset,
  output logic                                           rx_enable,
  output logic                                           rx_abort,
  output logic                                           rx_iq_valid,
  output rfc_iq_t                                        rx_iq,
  output logic [RFC_NUM_PATHS-1:0][RFC_PH_OUT_W-1:0]     path_phase,
  input  wire logic                                      path_pkt_valid,
  output logic                                           path_pkt_ready,
  input  wire logic [RFC_PKT_W-1:0]                      path_pkt,
  output logic                                           host_pkt_valid,
  input  wire logic                                      host_pkt_ready,
  output logic [RFC_PKT_W-1:0]                           host_pkt,
  input  wire logic                                      tx_req_valid,
  output logic                                           tx_req_ready,
  input  wire rfc_tx_cfg_t                               tx_req,
  output logic                                           tx_busy,
  output rfc_tx_cfg_t                                    tx_cfg,
  input  wire logic                                      tx_samp_valid,
  output logic                                           tx_samp_ready,
  input  wire rfc_iq_t                                   tx_samp,
  input  wire logic                                      tx_samp_last,
  output rfc_sd_t                                        tx_sd_a,
  output rfc_sd_t                                        tx_sd_b,
  output logic                                           tx_en_a,
  output logic                                           tx_en_b,
  output logic                                           tx_reject,
  input  wire logic                                      tx_reject_clr
);
  typedef struct packed {
    rfc_ctl_t                                   ctl;
    logic [31:0]                                cal_cnt;
    logic [7:0]                                 nco;
    logic [2:0]                                 pin_m;
    logic [2:0]                                 pin_s;
    logic [RFC_NIB_W-1:0]                       nib_m;
    logic [RFC_NIB_W-1:0]                       nib_s;
    logic                                       clk_d;
    logic [RFC_NIB_W*RFC_GRP_LEN-1:0]           grp;
    logic [3:0]                                 grp_cnt;
    logic                                       iq_valid;
    rfc_iq_t                                    iq;
    logic [RFC_NUM_PATHS-1:0][RFC_IF_W-1:0]     ph;
    logic                                       abort;
    rfc_tx_cfg_t                                cfg;
    rfc_iq_t                                    hold;
    logic [RFC_IQ_W-1:0]                        acc_i;
    logic [RFC_IQ_W-1:0]                        acc_q;
    rfc_sd_t                                    sd_a;
    rfc_sd_t                                    sd_b;
    logic                                       en_a;
    logic                                       en_b;
    logic                                       rej;
  } rfc_top_st_t;

  rfc_top_st_t s_r;
  rfc_top_st_t s_nxt;
  logic        tick;
  logic        rx_fall;
  logic        tx_take;
  logic        tx_start;
  logic        grp_done;
  logic        fifo_in_ready;
  rfc_iq_t     raw;
  rfc_iq_t     txc;
  rfc_sd_t     sd;
  logic [RFC_IQ_W:0] sum_i;
  logic [RFC_IQ_W:0] sum_q;

  // Signed fixed-point product scaled back by the correction fraction.
  function automatic logic signed [RFC_IQ_W-1:0] rfc_mulq(
    input logic signed [RFC_IQ_W-1:0] a,
    input logic signed [RFC_IQ_W-1:0] b
  );
    logic signed [2*RFC_IQ_W-1:0] p;
    p = a * b;
    return p[RFC_CORR_FRAC +: RFC_IQ_W];
  endfunction

  // First-order sigma-delta step: the carry out of the accumulator is the bit.
  function automatic logic [RFC_IQ_W:0] rfc_sd_step(
    input logic [RFC_IQ_W-1:0]        acc,
    input logic signed [RFC_IQ_W-1:0] x
  );
    logic [RFC_IQ_W-1:0] u;
    u = {~x[RFC_IQ_W-1], x[RFC_IQ_W-2:0]};
    return {1'b0, acc} + {1'b0, u};
  endfunction

  rfc_spi u_spi (
    .clock          (clock),
    .resetn         (resetn),
    .cs_active_high (cs_active_high),
    .req_valid      (spi_req_valid),
    .req_ready      (spi_req_ready),
    .req            (spi_req),
    .rd_valid       (spi_rd_valid),
    .rd_data        (spi_rd_data),
    .sck            (spi_sck),
    .mosi           (spi_mosi),
    .cs             (spi_cs),
    .miso           (spi_miso)
  );

  // Packets keep arriving while a transmit runs, but not while calibrating.
  rfc_fifo #(
    .WIDTH (RFC_PKT_W),
    .DEPTH (RFC_FIFO_DEPTH)
  ) u_rxbuf (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (path_pkt_valid & (s_r.ctl != RFC_CTL_CAL)), // [R11] [R03]
    .in_ready  (fifo_in_ready),
    .in_data   (path_pkt),
    .out_valid (host_pkt_valid),
    .out_ready (host_pkt_ready),
    .out_data  (host_pkt)
  );

  assign path_pkt_ready = fifo_in_ready & (s_r.ctl != RFC_CTL_CAL); // [R03]

  // Fractional divider: 32 ticks for every 250 clocks gives the sample rate.
  assign tick = (s_r.nco >= 8'(RFC_CLK_MHZ - RFC_SMP_MHZ)); // [R10]

  // The receive clock is only sampled, never used as a clock, so the
  // front end's falling edge is seen a few cycles late but consistently.
  assign rx_fall  = s_r.clk_d & ~s_r.pin_s[2]; // [R14]
  assign grp_done = rx_fall & (s_r.grp_cnt == 4'(RFC_GRP_LEN - 1)) & ~s_r.pin_s[1]; // [R15]

  assign raw.i = s_r.grp[RFC_NIB_W*RFC_GRP_LEN-1 -: RFC_IQ_W];
  assign raw.q = s_r.grp[RFC_NIB_W*RFC_GRP_LEN-1-RFC_IQ_W -: RFC_IQ_W];

  assign tx_req_ready  = 1'b1;
  assign tx_start      = tx_req_valid & (s_r.ctl == RFC_CTL_IDLE) & ~cal_start; // [R06]
  assign tx_samp_ready = tick & (s_r.ctl == RFC_CTL_TX);
  assign tx_take       = tx_samp_valid & tx_samp_ready;

  // Carrier leakage is removed before modulation.
  always_comb
  begin
    txc.i = (tx_take ? tx_samp.i : s_r.hold.i) - cal_dc.i; // [R05]
    txc.q = (tx_take ? tx_samp.q : s_r.hold.q) - cal_dc.q; // [R05]
    sum_i = rfc_sd_step(s_r.acc_i, txc.i);
    sum_q = rfc_sd_step(s_r.acc_q, txc.q);
    sd.i  = sum_i[RFC_IQ_W];
    sd.q  = sum_q[RFC_IQ_W];
  end

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.abort    = 1'b0;
    s_nxt.iq_valid = 1'b0;
    s_nxt.nco      = tick ? s_r.nco + 8'(RFC_SMP_MHZ) - 8'(RFC_CLK_MHZ)
                          : s_r.nco + 8'(RFC_SMP_MHZ);

    s_nxt.pin_m = {rx_clk_pin, rx_valid_pin, 1'b0};
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.nib_m = rx_data_pin;
    s_nxt.nib_s = s_r.nib_m;
    s_nxt.clk_d = s_r.pin_s[2];

    // Receive deinterleaver; its pins are separate from the transmit side.
    if (rx_fall) // [R09]
    begin
      if (s_r.pin_s[1])
      begin
        s_nxt.grp     = {{(RFC_NIB_W*(RFC_GRP_LEN-1)){1'b0}}, s_r.nib_s};
        s_nxt.grp_cnt = 4'h1;
      end
      else if (s_r.grp_cnt != 4'h0)
      begin
        s_nxt.grp     = {s_r.grp[RFC_NIB_W*(RFC_GRP_LEN-1)-1:0], s_r.nib_s};
        s_nxt.grp_cnt = (s_r.grp_cnt == 4'(RFC_GRP_LEN - 1)) ? 4'h0 : s_r.grp_cnt + 1'b1;
      end
    end

    // Only the top 24 bits of a full group form the I/Q pair.
    if (grp_done && s_r.ctl == RFC_CTL_IDLE && !cal_start && !tx_start) // [R03] [R07]
    begin
      s_nxt.grp       = {s_r.grp[RFC_NIB_W*(RFC_GRP_LEN-1)-1:0], s_r.nib_s};
      s_nxt.iq_valid  = 1'b1;
      s_nxt.iq.i      = s_nxt.grp[RFC_NIB_W*RFC_GRP_LEN-1 -: RFC_IQ_W];
      s_nxt.iq.q      = rfc_mulq(s_nxt.grp[RFC_NIB_W*RFC_GRP_LEN-1-RFC_IQ_W -: RFC_IQ_W],
                                 cal_gain)
                      + rfc_mulq(s_nxt.grp[RFC_NIB_W*RFC_GRP_LEN-1 -: RFC_IQ_W],
                                 cal_phase); // [R05]
      for (int k = 0; k < RFC_NUM_PATHS; k++)
        s_nxt.ph[k] = s_r.ph[k] + if_offset[k]; // [R13]
    end

    unique case (s_r.ctl)
      RFC_CTL_IDLE:
        if (cal_start)
        begin
          s_nxt.ctl     = RFC_CTL_CAL; // [R04]
          s_nxt.cal_cnt = '0;
          s_nxt.abort   = 1'b1; // [R03]
        end
        else if (tx_start)
        begin
          s_nxt.ctl   = RFC_CTL_TX;
          s_nxt.cfg   = tx_req; // [R08] [R12]
          s_nxt.abort = 1'b1; // [R07]
          s_nxt.acc_i = '0;
          s_nxt.acc_q = '0;
          s_nxt.hold  = '0;
        end
      RFC_CTL_CAL:
        // The controller runs the calibration on its own; here we only time it.
        if (s_r.cal_cnt == CAL_CYCLES - 1) // [R03] [R04]
          s_nxt.ctl = RFC_CTL_IDLE;
        else
          s_nxt.cal_cnt = s_r.cal_cnt + 1'b1;
      RFC_CTL_TX:
        if (cal_start)
        begin
          // Calibration wins: the running packet is cut short.
          s_nxt.ctl     = RFC_CTL_CAL; // [R03]
          s_nxt.cal_cnt = '0;
        end
        else if (tick)
        begin
          s_nxt.acc_i = sum_i[RFC_IQ_W-1:0]; // [R10]
          s_nxt.acc_q = sum_q[RFC_IQ_W-1:0];
          if (tx_take)
            s_nxt.hold = tx_samp;
          if (tx_take && tx_samp_last)
            s_nxt.ctl = RFC_CTL_IDLE;
        end
      default:
        s_nxt.ctl = RFC_CTL_IDLE;
    endcase

    // Only the chosen radio toggles; the other is held quiet.
    s_nxt.en_a = (s_nxt.ctl == RFC_CTL_TX) & ~s_nxt.cfg.radio; // [R08]
    s_nxt.en_b = (s_nxt.ctl == RFC_CTL_TX) & s_nxt.cfg.radio;
    if (s_r.ctl == RFC_CTL_TX && tick)
    begin
      s_nxt.sd_a = s_r.cfg.radio ? '0 : sd;
      s_nxt.sd_b = s_r.cfg.radio ? sd : '0;
    end
    else if (s_nxt.ctl != RFC_CTL_TX)
    begin
      s_nxt.sd_a = '0;
      s_nxt.sd_b = '0;
    end

    // A set in the same cycle as a clear is kept.
    if (tx_reject_clr)
      s_nxt.rej = 1'b0;
    if (tx_req_valid && !tx_start)
      s_nxt.rej = 1'b1; // [R16] [R06]
  end

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;

  assign cal_busy    = (s_r.ctl == RFC_CTL_CAL);
  assign rx_enable   = (s_r.ctl == RFC_CTL_IDLE);
  assign rx_abort    = s_r.abort;
  assign rx_iq_valid = s_r.iq_valid;
  assign rx_iq       = s_r.iq;
  assign tx_busy     = (s_r.ctl == RFC_CTL_TX);
  assign tx_cfg      = s_r.cfg;
  assign tx_sd_a     = s_r.sd_a;
  assign tx_sd_b     = s_r.sd_b;
  assign tx_en_a     = s_r.en_a;
  assign tx_en_b     = s_r.en_b;
  assign tx_reject   = s_r.rej;

  always_comb
    for (int k = 0; k < RFC_NUM_PATHS; k++)
      path_phase[k] = s_r.ph[k][RFC_IF_W-1 -: RFC_PH_OUT_W];

endmodule
`default_nettype wire

//--- test/rfc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_top_asserts
  import rfc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = RFC_CAL_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic tx_busy,
  input wire logic tx_req_valid,
  input wire logic tx_reject,
  input wire logic tx_en_a,
  input wire logic tx_en_b,
  input wire logic rx_abort,
  input wire logic rx_iq_valid,
  input wire logic path_pkt_ready,
  input wire logic spi_req_valid,
  input wire logic spi_req_ready,
  input wire logic spi_rd_valid,
  input wire logic spi_sck,
  input wire logic spi_cs,
  input wire logic cs_active_high
);
  logic [31:0] cal_cnt_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Counting busy cycles lets the lockout length be checked to the exact cycle.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      cal_cnt_r <= '0;
    else
      cal_cnt_r <= cal_busy ? cal_cnt_r + 32'h0000_0001 : '0;
  property p_one_radio; !(tx_en_a && tx_en_b); endproperty
  a_one_radio: assert property (p_one_radio)
    else $error("both radios enabled at once");
  property p_cal_no_tx; cal_busy |-> !tx_busy; endproperty
  a_cal_no_tx: assert property (p_cal_no_tx)
    else $error("transmit active during calibration");
  property p_cal_no_rx; cal_busy |-> !rx_iq_valid && !path_pkt_ready; endproperty
  a_cal_no_rx: assert property (p_cal_no_rx)
    else $error("receive active during calibration");
  property p_tx_abort; $rose(tx_busy) |-> rx_abort || $past(rx_abort); endproperty
  a_tx_abort: assert property (p_tx_abort)
    else $error("transmit start without receive abort");
  property p_tx_refuse; (tx_busy || cal_busy) && tx_req_valid |=> tx_reject; endproperty
  a_tx_refuse: assert property (p_tx_refuse)
    else $error("overlapping transmit request not flagged");
  property p_cal_start; cal_start && !cal_busy |=> cal_busy; endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start");
  property p_cal_len; $fell(cal_busy) |-> cal_cnt_r == CAL_CYCLES; endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration length wrong");
  property p_spi_frame; spi_req_valid && spi_req_ready |-> ##[200:300] spi_rd_valid; endproperty
  a_spi_frame: assert property (p_spi_frame)
    else $error("serial transaction did not complete");
  property p_cs_level; $changed(spi_sck) |-> spi_cs == cs_active_high; endproperty
  a_cs_level: assert property (p_cs_level)
    else $error("serial clock moved while chip select inactive");
endmodule
`default_nettype wire

//--- test/rfc_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_radio_model (
  input  wire logic        clock,
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        cs,
  input  wire logic        cs_active_high,
  input  wire logic [7:0]  reply,
  output var  logic        miso,
  output var  logic [15:0] word
);
  logic [4:0] n;
  wire        sel = (cs == cs_active_high);
  initial {miso, word, n} = '0;
  always @(posedge sck)
    if (sel)
    begin
      word <= {word[14:0], mosi};
      n <= n + 5'h01;
    end
  // Unselected or outside the data byte the line toggles, so stale bits never look valid.
  always @(negedge sck)
    miso <= (sel && n[3]) ? reply[5'h0f - n] : ~miso;
  always @(posedge clock)
    if (!sel)
    begin
      n <= '0;
      miso <= ~miso;
    end
endmodule
`default_nettype wire

//--- test/test_rfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_rfc_top
  import rfc_pkg::*;
;
  localparam int CAL_CYCLES = 50;
  typedef struct packed {logic pol; rfc_spi_req_t req; logic [7:0] rep;} rfc_spi_row_t;
  localparam rfc_spi_row_t ROWS [3] = '{'{1'b0, 16'h8255, 8'h3c}, '{1'b1, 16'h7f00, 8'hc3},
                                        '{1'b0, 16'h00ff, 8'ha5}};
  logic clock, resetn, cal_start, cal_busy, cs_active_high, spi_req_valid, spi_req_ready;
  logic spi_rd_valid, spi_sck, spi_mosi, spi_cs, spi_miso, rx_clk_pin, rx_valid_pin;
  logic rx_enable, rx_abort, rx_iq_valid, path_pkt_valid, path_pkt_ready, host_pkt_valid;
  logic host_pkt_ready, tx_req_valid, tx_req_ready, tx_busy, tx_samp_valid, tx_samp_ready;
  logic tx_samp_last, tx_en_a, tx_en_b, tx_reject, tx_reject_clr;
  logic        [7:0]                                    spi_rd_data, reply;
  logic        [15:0]                                   word;
  logic        [3:0]                                    rx_data_pin;
  logic        [RFC_NUM_PATHS-1:0][RFC_IF_W-1:0]        if_offset;
  logic        [RFC_NUM_PATHS-1:0][RFC_PH_OUT_W-1:0]    path_phase;
  logic        [31:0]                                   path_pkt, host_pkt;
  logic signed [11:0]                                   cal_gain, cal_phase;
  rfc_iq_t                                              cal_dc, rx_iq, tx_samp;
  rfc_spi_req_t                                         spi_req;
  rfc_tx_cfg_t                                          tx_req, tx_cfg;
  rfc_sd_t                                              tx_sd_a, tx_sd_b;
  int                                                   err_total, compares, cyc, n;
  rfc_top #(.CAL_CYCLES(CAL_CYCLES)) u_rfc_top (.*);
  rfc_radio_model u_rfc_radio_model (.clock(clock), .sck(spi_sck), .mosi(spi_mosi), .cs(spi_cs),
    .cs_active_high(cs_active_high), .reply(reply), .miso(spi_miso), .word(word));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic tick; @(posedge clock); endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    repeat (lim)
    begin
      #1;
      if (s === v) break;
      tick;
    end
    chk(s, v);
  endtask
  task automatic final_report;
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // The far side changes pins on its rising clock, one marker per group of eight nibbles.
  task automatic rx_group(input logic [31:0] w);
    for (int i = 0; i < 8; i++)
    begin
      tick;
      rx_clk_pin <= 1'b1;
      rx_valid_pin <= (i == 0);
      rx_data_pin <= w[31-4*i -: 4];
      repeat (4) tick;
      rx_clk_pin <= 1'b0;
      repeat (3) tick;
    end
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      final_report;
    end
  end
  initial
  begin
    {cal_start, cs_active_high, spi_req_valid, spi_req, rx_clk_pin, rx_valid_pin, rx_data_pin,
     cal_dc, cal_phase, path_pkt_valid, path_pkt, host_pkt_ready, tx_req_valid, tx_req, tx_samp,
     tx_samp_last, tx_reject_clr, reply, resetn, err_total, compares, cyc} = '0;
    cal_gain = 12'sh400;
    tx_samp_valid = 1'b1;
    foreach (if_offset[p]) if_offset[p] = 16'(p * 16'h1100);
    repeat (5) tick;
    #1 chk({spi_req_ready, rx_enable, tx_req_ready, tx_busy, cal_busy}, 5'b11100);
    tick;
    resetn <= 1'b1;
    repeat (2) tick;
    foreach (ROWS[r])
    begin
      tick;
      cs_active_high <= ROWS[r].pol;
      reply <= ROWS[r].rep;
      repeat (3) tick;
      #1 chk(spi_cs, !ROWS[r].pol);
      tick;
      spi_req <= ROWS[r].req;
      spi_req_valid <= 1'b1;
      tick;
      spi_req_valid <= 1'b0;
      wait_on(spi_rd_valid, 1'b1, 400);
      chk(spi_rd_data, ROWS[r].rep);
      chk(word, ROWS[r].req);
    end
    rx_group(32'h4a51_c3e7);
    wait_on(rx_iq_valid, 1'b1, 20);
    chk(rx_iq, 24'h4a5_1c3);
    repeat (3) tick;
    foreach (path_phase[p]) chk(path_phase[p], 8'(p * 8'h11));
    for (int c = 0; c < 4; c++)
    begin
      tick;
      tx_req <= 2'(c);
      tx_req_valid <= 1'b1;
      tx_samp <= {c[11:0], ~c[11:0]};
      tick;
      tx_req <= 2'(~c);
      tick;
      tx_req_valid <= 1'b0;
      #1 chk({tx_busy, tx_reject, rx_enable, tx_cfg, tx_en_a, tx_en_b, c[1] ? tx_sd_a : tx_sd_b},
             {3'b110, 2'(c), ~c[1], c[1], 2'b00});
      n = 0;
      repeat (250)
      begin
        #1 n += int'(tx_samp_ready === 1'b1);
        tick;
      end
      chk(n, 32);
      tx_reject_clr <= 1'b1;
      tx_samp_last <= 1'b1;
      tick;
      tx_reject_clr <= 1'b0;
      #1 chk(tx_reject, 1'b0);
      wait_on(tx_busy, 1'b0, 20);
      tick;
      tx_samp_last <= 1'b0;
      #1 chk({tx_busy, tx_en_a, tx_en_b}, 3'b000);
    end
    tick;
    cal_start <= 1'b1;
    tick;
    cal_start <= 1'b0;
    tx_req_valid <= 1'b1;
    path_pkt_valid <= 1'b1;
    tick;
    tx_req_valid <= 1'b0;
    path_pkt_valid <= 1'b0;
    #1 chk({cal_busy, tx_busy, tx_reject, path_pkt_ready, host_pkt_valid}, 5'b10100);
    wait_on(cal_busy, 1'b0, 80);
    tick;
    tx_reject_clr <= 1'b1;
    n = 0;
    tick;
    tx_reject_clr <= 1'b0;
    path_pkt_valid <= 1'b1;
    path_pkt <= '0;
    repeat (20)
    begin
      #1 n += int'(path_pkt_ready === 1'b1);
      tick;
      path_pkt <= 32'(n);
    end
    path_pkt_valid <= 1'b0;
    host_pkt_ready <= 1'b1;
    chk(n, 16);
    for (int i = 0; i < 16; i++)
    begin
      #1 chk({host_pkt_valid, host_pkt}, {1'b1, 32'(i)});
      tick;
    end
    #1 chk(host_pkt_valid, 1'b0);
    final_report;
  end
endmodule
bind rfc_top rfc_top_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_rfc_top_asserts (.*);
`default_nettype wire
